// ==== core/ppfm_consts.vh ====
// register offsets, field layout and reset values of the port pin function mux
`ifndef PPFM_CONSTS_VH
`define PPFM_CONSTS_VH
`define PPFM_ADDR_W 5
`define PPFM_P1_IN 5'h00
`define PPFM_P1_OUT 5'h01
`define PPFM_P1_DIR 5'h02
`define PPFM_P1_IFG 5'h03
`define PPFM_P1_IES 5'h04
`define PPFM_P1_IE 5'h05
`define PPFM_P1_SEL 5'h06
`define PPFM_P2_IN 5'h08
`define PPFM_P2_OUT 5'h09
`define PPFM_P2_DIR 5'h0a
`define PPFM_P2_IFG 5'h0b
`define PPFM_P2_IES 5'h0c
`define PPFM_P2_IE 5'h0d
`define PPFM_P2_SEL 5'h0e
`define PPFM_RST_BYTE 8'h00
`define PPFM_P2_BONDED 8'h3f
`define PPFM_P1_CLK_BIT 0
`define PPFM_P1_SUBSYSTEM_CLOCK_BIT 4
`define PPFM_P2_ACLK_BIT 0
`define PPFM_P2_ALTCLK_BIT 1
`endif

// ==== core/ppfm_port_regs.v ====
// one 8-bit port: output, direction, select, enable, edge select and flag registers
`timescale 1ns/1ps
`include "ppfm_consts.vh"
module ppfm_port_regs #(
    parameter [7:0] HW_EVENT_MASK = 8'hff
) (
    input wire clk_sys,
    input wire rst_n,
    input wire wr_out,
    input wire wr_dir,
    input wire wr_ifg,
    input wire wr_ies,
    input wire wr_ie,
    input wire wr_sel,
    input wire [7:0] wdata,
    input wire [7:0] pin_in,
    output reg [7:0] out_value,
    output reg [7:0] dir_value,
    output reg [7:0] ifg_value,
    output reg [7:0] ies_value,
    output reg [7:0] ie_value,
    output reg [7:0] sel_value,
    output reg [7:0] in_value
);
    wire [7:0] rise;
    wire [7:0] fall;
    wire [7:0] edge_hit;
    reg [7:0] next_ifg;

    // edges against the previous sampled input; unbonded bits masked off
    assign rise = pin_in & ~in_value;
    assign fall = ~pin_in & in_value;
    assign edge_hit = ((rise & ~ies_value) | (fall & ies_value)) & HW_EVENT_MASK;

    // a hardware edge wins over a software write in the same cycle
    always @* begin
        next_ifg = wr_ifg ? wdata : ifg_value;
        next_ifg = next_ifg | edge_hit;
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_value <= `PPFM_RST_BYTE;
            dir_value <= `PPFM_RST_BYTE;
            ifg_value <= `PPFM_RST_BYTE;
            ies_value <= `PPFM_RST_BYTE;
            ie_value <= `PPFM_RST_BYTE;
            sel_value <= `PPFM_RST_BYTE;
            in_value <= `PPFM_RST_BYTE;
        end else begin
            in_value <= pin_in;
            ifg_value <= next_ifg;
            if (wr_out) begin
                out_value <= wdata;
            end
            if (wr_dir) begin
                dir_value <= wdata;
            end
            if (wr_ies) begin
                ies_value <= wdata;
            end
            if (wr_ie) begin
                ie_value <= wdata;
            end
            if (wr_sel) begin
                sel_value <= wdata;
            end
        end
    end
endmodule // ppfm_port_regs

// ==== core/ppfm_pin_mux.v ====
// per-bit output multiplexer: port value or peripheral, enable from direction
`timescale 1ns/1ps
module ppfm_pin_mux (
    input wire [7:0] sel_value,
    input wire [7:0] out_value,
    input wire [7:0] dir_value,
    input wire [7:0] periph_out,
    output wire [7:0] pin_value,
    output wire [7:0] pin_drive
);
    // select one takes the peripheral, zero the port output bit
    assign pin_value = (sel_value & periph_out) | (~sel_value & out_value);
    // the peripheral never touches direction
    assign pin_drive = dir_value;
endmodule // ppfm_pin_mux

// ==== core/ppfm_top.v ====
// port pin function mux for two 8-bit ports with register access and port interrupts
// Operation
// - select bit picks port or peripheral output
// - pin drive enable always from direction bit
// - port1 bit0: low output, input clocks timer
// - port1 bits1-3: compares out, captures A in
// - port1 bit4 outputs subsystem clock, input plain
// - port1 bits5-7 output compares, inputs unused
// - port2 bit0 outputs auxiliary clock
// - port2 bit1: low output, timer alternate clock
// - port2 bits2-4 compares; bits2-3 captures B
// - port2 bits6-7 unbonded, registers still present
// - unbonded flags change only by software
// - each bit has enable, flag, edge select
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "ppfm_consts.vh"
module ppfm_top (
    input wire clk_sys,
    input wire rst_n,
    input wire [`PPFM_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire [7:0] p1_pin_in,
    output reg [7:0] p1_pin_out,
    output reg [7:0] p1_pin_oe,
    input wire [5:0] p2_pin_in,
    output reg [5:0] p2_pin_out,
    output reg [5:0] p2_pin_oe,
    input wire compare0_output,
    input wire compare1_output,
    input wire compare2_output,
    input wire subsystem_clock,
    input wire aux_clock,
    output reg timer_ext_clock_in,
    output reg timer_alt_clock_in,
    output reg capture0_input_a,
    output reg capture1_input_a,
    output reg capture2_input_a,
    output reg capture0_input_b,
    output reg capture1_input_b,
    output reg p1_irq,
    output reg p2_irq
);
    wire [7:0] p1_out, p1_dir, p1_ifg, p1_ies, p1_ie, p1_sel, p1_in;
    wire [7:0] p2_out, p2_dir, p2_ifg, p2_ies, p2_ie, p2_sel, p2_in;
    wire [7:0] p1_periph, p2_periph;
    wire [7:0] p1_val, p1_drv, p2_val, p2_drv;
    wire [7:0] p2_pin_full;
    reg [7:0] next_rdata;

    // write strobe decode for one port register
    function wr_hit;
        input [`PPFM_ADDR_W-1:0] addr;
        input [`PPFM_ADDR_W-1:0] target;
        input strobe;
        begin
            wr_hit = strobe && (addr == target);
        end
    endfunction

    // peripheral outputs per bit; tied-low bits drive zero when selected
    assign p1_periph = {compare2_output, compare1_output, compare0_output,
                        subsystem_clock,
                        compare2_output, compare1_output, compare0_output,
                        1'b0};
    assign p2_periph = {1'b0, 1'b0,
                        1'b0, // p2 bit5 resistor function not modelled here
                        compare2_output, compare1_output, compare0_output,
                        1'b0,
                        aux_clock};
    // unbonded bits see a constant low so no edge ever reaches them
    assign p2_pin_full = {2'b00, p2_pin_in};

    ppfm_port_regs #(.HW_EVENT_MASK(8'hff)) u_p1 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_out(wr_hit(reg_addr, `PPFM_P1_OUT, reg_wr)),
        .wr_dir(wr_hit(reg_addr, `PPFM_P1_DIR, reg_wr)),
        .wr_ifg(wr_hit(reg_addr, `PPFM_P1_IFG, reg_wr)),
        .wr_ies(wr_hit(reg_addr, `PPFM_P1_IES, reg_wr)),
        .wr_ie(wr_hit(reg_addr, `PPFM_P1_IE, reg_wr)),
        .wr_sel(wr_hit(reg_addr, `PPFM_P1_SEL, reg_wr)),
        .wdata(reg_wdata),
        .pin_in(p1_pin_in),
        .out_value(p1_out),
        .dir_value(p1_dir),
        .ifg_value(p1_ifg),
        .ies_value(p1_ies),
        .ie_value(p1_ie),
        .sel_value(p1_sel),
        .in_value(p1_in)
    );

    ppfm_port_regs #(.HW_EVENT_MASK(`PPFM_P2_BONDED)) u_p2 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wr_out(wr_hit(reg_addr, `PPFM_P2_OUT, reg_wr)),
        .wr_dir(wr_hit(reg_addr, `PPFM_P2_DIR, reg_wr)),
        .wr_ifg(wr_hit(reg_addr, `PPFM_P2_IFG, reg_wr)),
        .wr_ies(wr_hit(reg_addr, `PPFM_P2_IES, reg_wr)),
        .wr_ie(wr_hit(reg_addr, `PPFM_P2_IE, reg_wr)),
        .wr_sel(wr_hit(reg_addr, `PPFM_P2_SEL, reg_wr)),
        .wdata(reg_wdata),
        .pin_in(p2_pin_full),
        .out_value(p2_out),
        .dir_value(p2_dir),
        .ifg_value(p2_ifg),
        .ies_value(p2_ies),
        .ie_value(p2_ie),
        .sel_value(p2_sel),
        .in_value(p2_in)
    );

    ppfm_pin_mux u_mux1 (
        .sel_value(p1_sel),
        .out_value(p1_out),
        .dir_value(p1_dir),
        .periph_out(p1_periph),
        .pin_value(p1_val),
        .pin_drive(p1_drv)
    );

    ppfm_pin_mux u_mux2 (
        .sel_value(p2_sel),
        .out_value(p2_out),
        .dir_value(p2_dir),
        .periph_out(p2_periph),
        .pin_value(p2_val),
        .pin_drive(p2_drv)
    );

    // read decode; unmapped addresses return zero
    always @* begin
        next_rdata = 8'h00;
        if (reg_addr == `PPFM_P1_IN) begin
            next_rdata = p1_in;
        end else if (reg_addr == `PPFM_P1_OUT) begin
            next_rdata = p1_out;
        end else if (reg_addr == `PPFM_P1_DIR) begin
            next_rdata = p1_dir;
        end else if (reg_addr == `PPFM_P1_IFG) begin
            next_rdata = p1_ifg;
        end else if (reg_addr == `PPFM_P1_IES) begin
            next_rdata = p1_ies;
        end else if (reg_addr == `PPFM_P1_IE) begin
            next_rdata = p1_ie;
        end else if (reg_addr == `PPFM_P1_SEL) begin
            next_rdata = p1_sel;
        end else if (reg_addr == `PPFM_P2_IN) begin
            next_rdata = p2_in;
        end else if (reg_addr == `PPFM_P2_OUT) begin
            next_rdata = p2_out;
        end else if (reg_addr == `PPFM_P2_DIR) begin
            next_rdata = p2_dir;
        end else if (reg_addr == `PPFM_P2_IFG) begin
            next_rdata = p2_ifg;
        end else if (reg_addr == `PPFM_P2_IES) begin
            next_rdata = p2_ies;
        end else if (reg_addr == `PPFM_P2_IE) begin
            next_rdata = p2_ie;
        end else if (reg_addr == `PPFM_P2_SEL) begin
            next_rdata = p2_sel;
        end
    end

    // all outputs registered: one cycle of latency on pins and timer inputs
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            p1_pin_out <= 8'h00;
            p1_pin_oe <= 8'h00;
            p2_pin_out <= 6'h00;
            p2_pin_oe <= 6'h00;
            timer_ext_clock_in <= 1'b0;
            timer_alt_clock_in <= 1'b0;
            capture0_input_a <= 1'b0;
            capture1_input_a <= 1'b0;
            capture2_input_a <= 1'b0;
            capture0_input_b <= 1'b0;
            capture1_input_b <= 1'b0;
            p1_irq <= 1'b0;
            p2_irq <= 1'b0;
        end else begin
            // read data stands in each cycle after a cycle with reg_rd high, zero otherwise
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
            p1_pin_out <= p1_val;
            p1_pin_oe <= p1_drv;
            p2_pin_out <= p2_val[5:0];
            p2_pin_oe <= p2_drv[5:0];
            timer_ext_clock_in <= p1_pin_in[`PPFM_P1_CLK_BIT];
            capture0_input_a <= p1_pin_in[1];
            capture1_input_a <= p1_pin_in[2];
            capture2_input_a <= p1_pin_in[3];
            timer_alt_clock_in <= p2_pin_in[`PPFM_P2_ALTCLK_BIT];
            capture0_input_b <= p2_pin_in[2];
            capture1_input_b <= p2_pin_in[3];
            p1_irq <= |(p1_ifg & p1_ie);
            p2_irq <= |(p2_ifg & p2_ie);
        end
    end
endmodule // ppfm_top

// ==== tb/ppfm_pins_model.sv ====
// board side of the ports: external drivers meeting the device pins
`timescale 1ns/1ps
module ppfm_pins_model (
    input wire [7:0] p1_pin_out,
    input wire [7:0] p1_pin_oe,
    input wire [5:0] p2_pin_out,
    input wire [5:0] p2_pin_oe,
    input wire [13:0] ext_lvl,
    output wire [7:0] p1_pin_in,
    output wire [5:0] p2_pin_in
);
    // the board lets go of a pin while the device drives it, so no contention
    assign p1_pin_in = (p1_pin_oe & p1_pin_out) | (~p1_pin_oe & ext_lvl[7:0]);
    assign p2_pin_in = (p2_pin_oe & p2_pin_out) | (~p2_pin_oe & ext_lvl[13:8]);
endmodule // ppfm_pins_model

// ==== tb/ppfm_monitor.sv ====
// assertion checker on the ports of the port pin function mux
`timescale 1ns/1ps
`include "ppfm_consts.vh"
module ppfm_monitor (
    input wire clk_sys,
    input wire rst_n,
    input wire [`PPFM_ADDR_W-1:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire [7:0] p1_pin_in,
    input wire [7:0] p1_pin_oe,
    input wire [5:0] p2_pin_in,
    input wire [5:0] p2_pin_oe,
    input wire timer_ext_clock_in,
    input wire timer_alt_clock_in,
    input wire capture0_input_a,
    input wire capture1_input_a,
    input wire capture2_input_a,
    input wire capture0_input_b,
    input wire capture1_input_b,
    input wire p1_irq,
    input wire p2_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // timer inputs trail the pins by one cycle; the first edge after reset still shows zero
    ext_clk_a: assert property ($past(rst_n) |->
        timer_ext_clock_in == $past(p1_pin_in[0])) else $error("timer clock lost pin");
    alt_clk_a: assert property ($past(rst_n) |->
        timer_alt_clock_in == $past(p2_pin_in[1])) else $error("alt clock lost pin");
    cap_a_a: assert property ($past(rst_n) |->
        {capture2_input_a, capture1_input_a, capture0_input_a} == $past(p1_pin_in[3:1]))
        else $error("capture a path wrong");
    cap_b_a: assert property ($past(rst_n) |->
        {capture1_input_b, capture0_input_b} == $past(p2_pin_in[3:2]))
        else $error("capture b path wrong");
    read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    // drive enable may only move two edges after a direction write
    p1_dir_a: assert property ($changed(p1_pin_oe) |->
        $past(reg_wr && reg_addr == `PPFM_P1_DIR, 2)) else $error("p1 enable moved alone");
    p2_dir_a: assert property ($changed(p2_pin_oe) |->
        $past(reg_wr && reg_addr == `PPFM_P2_DIR, 2)) else $error("p2 enable moved alone");
    reset_out_a: assert property ($rose(rst_n) |->
        p1_pin_oe == 8'h00 && p2_pin_oe == 6'h00 && !p1_irq && !p2_irq)
        else $error("outputs not clear after reset");
    cover property (reg_wr && reg_addr == `PPFM_P1_SEL);
    cover property ($rose(p1_irq));
    cover property ($rose(p2_irq));
endmodule // ppfm_monitor

bind ppfm_top ppfm_monitor ppfm_monitor_i (.*);

// ==== tb/tb.sv ====
// self-checking bench for the port pin function mux
`timescale 1ns/1ps
`include "ppfm_consts.vh"
module tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic compare0_output = 1'b0, compare1_output = 1'b0, compare2_output = 1'b0;
    logic subsystem_clock = 1'b0, aux_clock = 1'b0;
    logic [13:0] ext_lvl = 14'h0000;
    wire [7:0] reg_rdata, p1_pin_in, p1_pin_out, p1_pin_oe;
    wire [5:0] p2_pin_in, p2_pin_out, p2_pin_oe;
    wire timer_ext_clock_in, timer_alt_clock_in, capture0_input_b, capture1_input_b;
    wire capture0_input_a, capture1_input_a, capture2_input_a, p1_irq, p2_irq;
    int num_errors = 0;
    int comparisons = 0;
    typedef struct packed {logic [4:0] a; logic [7:0] d; logic [7:0] e;} ppfm_row_t;
    // write, then expected read back; input and unmapped places must read zero
    ppfm_row_t rows [16] = '{'{5'h01, 8'ha5, 8'ha5}, '{5'h02, 8'h5a, 8'h5a},
        '{5'h03, 8'h81, 8'h81}, '{5'h04, 8'hc3, 8'hc3}, '{5'h05, 8'h3c, 8'h3c},
        '{5'h06, 8'h0f, 8'h0f}, '{5'h09, 8'ha5, 8'ha5}, '{5'h0a, 8'h5a, 8'h5a},
        '{5'h0b, 8'hc0, 8'hc0}, '{5'h0c, 8'hc3, 8'hc3}, '{5'h0d, 8'h3c, 8'h3c},
        '{5'h0e, 8'h0f, 8'h0f}, '{5'h00, 8'hff, 8'h00}, '{5'h08, 8'hff, 8'h00},
        '{5'h07, 8'hff, 8'h00}, '{5'h1f, 8'hff, 8'h00}};
    // rise with select 0 flags, fall with select 0 does not, rise with select 1 does not,
    // fall with select 1 flags: both polarities of the edge select are exercised
    logic [3:0] irq_steps [4] = '{4'h3, 4'h0, 4'h6, 4'h5}; // edge select, level, request

    ppfm_top ppfm_top_i (.*);
    ppfm_pins_model ppfm_pins_model_i (.*);

    always #4 clk_sys = ~clk_sys;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // every access starts on its own edge so no strobe is assigned twice in a step
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, e);
    endtask
    task automatic wt;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic end_sim;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog: the sequence needs a few hundred cycles at most
    initial begin
        #100000;
        num_errors++;
        end_sim;
    end

    initial begin
        logic [13:0] e;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int a = 0; a < 16; a++) rd(a[4:0], 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        // reset in mid-run must clear everything again
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`PPFM_P1_SEL, 8'h00);
        wr(`PPFM_P1_DIR, 8'hff);
        wr(`PPFM_P2_DIR, 8'hff);
        wr(`PPFM_P1_SEL, 8'hff);
        wr(`PPFM_P2_SEL, 8'hff);
        for (int p = 0; p < 32; p++) begin
            @(posedge clk_sys);
            {aux_clock, subsystem_clock, compare2_output, compare1_output, compare0_output} <= p[4:0];
            wt;
            // port1 bit0 has a tied-low peripheral output, so it stays low when selected
            chk({p1_pin_out, p1_pin_oe},
                {p[2], p[1], p[0], p[3], p[2], p[1], p[0], 1'b0, 8'hff});
            chk({p2_pin_out, p2_pin_oe}, {1'b0, p[2], p[1], p[0], 1'b0, p[4], 6'h3f});
        end
        wr(`PPFM_P1_OUT, 8'ha5);
        wr(`PPFM_P1_SEL, 8'h00);
        wt;
        chk(p1_pin_out, 8'ha5);
        wr(`PPFM_P1_SEL, 8'hff);
        wr(`PPFM_P1_DIR, 8'h00);
        wr(`PPFM_P2_DIR, 8'h00);
        wt;
        chk({p1_pin_oe, 2'b00, p2_pin_oe}, 16'h0000);
        // pin inputs reach the timer and the input registers
        for (int k = 0; k < 4; k++) begin
            e = (k == 0) ? 14'h3fff : (k == 1) ? 14'h2aaa : (k == 2) ? 14'h1555 : 14'h0000;
            @(posedge clk_sys);
            ext_lvl <= e;
            wt;
            chk({capture1_input_b, capture0_input_b, capture2_input_a, capture1_input_a,
                capture0_input_a, timer_alt_clock_in, timer_ext_clock_in},
                {e[11], e[10], e[3], e[2], e[1], e[9], e[0]});
            rd(`PPFM_P1_IN, e[7:0]);
            rd(`PPFM_P2_IN, {2'b00, e[13:8]});
        end
        // each edge select against each edge direction
        wr(`PPFM_P1_IE, 8'h01);
        foreach (irq_steps[i]) begin
            wr(`PPFM_P1_IES, {7'h00, irq_steps[i][2]});
            wr(`PPFM_P1_IFG, 8'h00);
            @(posedge clk_sys);
            ext_lvl[0] <= irq_steps[i][1];
            wt;
            chk(p1_irq, irq_steps[i][0]);
        end
        // unbonded bits ignore pin activity but take software writes
        wr(`PPFM_P2_IFG, 8'h00);
        wr(`PPFM_P2_IE, 8'hc0);
        @(posedge clk_sys);
        ext_lvl[13:8] <= 6'h3f;
        wt;
        rd(`PPFM_P2_IFG, 8'h3f);
        chk(p2_irq, 1'b0);
        wr(`PPFM_P2_IFG, 8'hc0);
        wt;
        chk(p2_irq, 1'b1);
        end_sim;
    end
endmodule // tb
